// [pms_pkg.sv]
package pms_pkg;
    // ------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------
    localparam logic [4:0] REG_BASIC_CONTROL   = 5'h00;
    localparam logic [4:0] REG_BASIC_STATUS    = 5'h01;
    localparam logic [4:0] REG_IDENTIFIER_HIGH = 5'h02;
    localparam logic [4:0] REG_IDENTIFIER_LOW  = 5'h03;
    localparam logic [4:0] REG_STD_LAST        = 5'h06;
    localparam logic [4:0] REG_VENDOR_FIRST    = 5'h10;
    localparam logic [4:0] REG_MODE_CTRL       = 5'h11;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTL_RESET    = 15;
    localparam int CTL_LOOPBACK = 14;
    localparam int CTL_SPEED    = 13;
    localparam int CTL_AN_EN    = 12;
    localparam int CTL_PWRDN    = 11;
    localparam int CTL_ISOLATE  = 10;
    localparam int CTL_AN_RST   = 9;
    localparam int CTL_DUPLEX   = 8;
    localparam int CTL_COLTEST  = 7;
    localparam int MODE_ANY_ADDR = 3;
    // ------------------------------------------------------------
    // Values
    // ------------------------------------------------------------
    localparam logic [15:0] CTL_RESET_VAL  = 16'h3100;
    localparam logic [15:0] CTL_WR_MASK    = 16'hFF80;
    localparam logic [15:0] STATUS_CAPS    = 16'h7809;
    localparam logic [15:0] UNIMPL_VALUE   = 16'hFFFF;
    localparam logic [4:0]  ADDR_DEFAULT   = 5'h1F;
    localparam logic [1:0]  OP_WRITE       = 2'h1;
    localparam logic [1:0]  OP_READ        = 2'h2;
    localparam int          PREAMBLE_BITS  = 32;
    // Management clock limits, far side only
    localparam int MDC_MIN_EDGE_NS   = 160;
    localparam int MDC_MIN_PERIOD_NS = 400;
    localparam int CLK_PERIOD_NS     = 4;
    localparam int MDC_EDGE_CYCLES   = MDC_MIN_EDGE_NS / CLK_PERIOD_NS;
endpackage

// [pms_regs_if.sv]
`timescale 1ns/1ps
interface pms_regs_if;
    logic        wr_stb;
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        any_addr;

    modport frame (output wr_stb, output addr, output wdata, input rdata, input any_addr);
    modport regs  (input wr_stb, input addr, input wdata, output rdata, output any_addr);
endinterface

// [pms_regfile.sv]
`timescale 1ns/1ps
module pms_regfile #(
    parameter logic [15:0] ID_HIGH = 16'h1234, // Arbitrary value
    parameter logic [15:0] ID_LOW  = 16'h5670  // Arbitrary value
) (
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    input  wire logic  link_up_i,
    input  wire logic  an_done_i,
    pms_regs_if.regs   rb,
    output logic [15:0] control_o,
    output logic        an_restart_o
);
    logic [15:0] ctl_reg;
    logic [15:0] vend_reg [16];
    logic [15:0] status_w;
    logic        ctl_wr;
    logic        soft_reset;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign ctl_wr     = rb.wr_stb && (rb.addr == pms_pkg::REG_BASIC_CONTROL);
    assign soft_reset = ctl_wr && rb.wdata[pms_pkg::CTL_RESET];
    // Negotiation done in bit 5, link in bit 2
    assign status_w   = pms_pkg::STATUS_CAPS | {10'h000, an_done_i, 2'h0, link_up_i, 2'h0};
    assign rb.any_addr = vend_reg[1][pms_pkg::MODE_ANY_ADDR];
    assign control_o   = ctl_reg;
    // Restart bit self-clears, so a write of one is a pulse
    assign an_restart_o = ctl_wr && rb.wdata[pms_pkg::CTL_AN_RST];

    // Read mux: 7..15 answer all ones
    assign rb.rdata =
        (rb.addr == pms_pkg::REG_BASIC_CONTROL)   ? ctl_reg :
        (rb.addr == pms_pkg::REG_BASIC_STATUS)    ? status_w :
        (rb.addr == pms_pkg::REG_IDENTIFIER_HIGH) ? ID_HIGH :
        (rb.addr == pms_pkg::REG_IDENTIFIER_LOW)  ? ID_LOW :
        (rb.addr <= pms_pkg::REG_STD_LAST)        ? 16'h0000 :
        (rb.addr >= pms_pkg::REG_VENDOR_FIRST)    ? vend_reg[rb.addr[3:0]] :
        pms_pkg::UNIMPL_VALUE;

    // Control register; reset and restart bits never stick
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctl_reg <= pms_pkg::CTL_RESET_VAL;
        end else if (soft_reset) begin
            ctl_reg <= pms_pkg::CTL_RESET_VAL;
        end else if (ctl_wr) begin
            ctl_reg <= rb.wdata & pms_pkg::CTL_WR_MASK & 16'h7DFF;
        end
    end

    // Vendor registers 16..31 as plain storage
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_vend
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    vend_reg[gi] <= 16'h0000;
                end else if (rb.wr_stb && rb.addr == {1'b1, 4'(gi)}) begin
                    vend_reg[gi] <= rb.wdata;
                end
            end
        end
    endgenerate
endmodule

// [pms_top.sv]
`timescale 1ns/1ps
// Function
// - Latch mode strap at reset release
// - Latch five-bit address from four light pins and general output 1
// - Light polarity follows its address strap
// - Registers 0-6 and 16-31 implemented
// - Registers 7-15 read as all ones
// - Vendor bit answers any address
// - Data sampled on management clock rise
// - Open-drain data, clock only an input
// - No timeout; frame state held forever
// - Control register bit layout
// - Restart pulse; forced speed and duplex
module pms_top #(
    parameter logic [15:0] ID_HIGH = 16'h1234, // Arbitrary value
    parameter logic [15:0] ID_LOW  = 16'h5670  // Arbitrary value
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       mdc_i,
    input  wire logic       mdio_i,
    output logic            mdio_o,
    output logic            mdio_oe_n_o,
    input  wire logic [3:0] status_light_i,
    input  wire logic       general_output_1_i,
    input  wire logic       mode_strap_pin_i,
    input  wire logic [3:0] light_on_i,
    input  wire logic       link_up_i,
    input  wire logic       an_done_i,
    input  wire logic       irq_req_i,
    input  wire logic       tx_err_i,
    output logic [3:0]      status_light_o,
    output logic            status_light_oe_n_o,
    output logic            shared_pin_o,
    output logic            int_mode_o,
    output logic [4:0]      phy_address_o,
    output logic [15:0]     control_o,
    output logic            an_enable_o,
    output logic            speed_100_o,
    output logic            full_duplex_o,
    output logic            an_restart_o
);
    typedef enum logic [2:0] {
        PMS_IDLE  = 3'b000,
        PMS_HEAD  = 3'b001,
        PMS_TA    = 3'b010,
        PMS_DATA  = 3'b011,
        PMS_SKIP  = 3'b100
    } pms_state_t;

    pms_regs_if rif ();

    // ------------------------------------------------------------
    // Synchronisers and strap capture
    // ------------------------------------------------------------
    logic [1:0]  mdc_s_reg, mdio_s_reg;
    logic [5:0]  strap_s1_reg, strap_s2_reg;
    logic        mdc_d_reg;
    logic        rel_reg;
    logic        strap_done_reg;
    logic [4:0]  addr_reg;
    logic        int_mode_reg;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mdc_s_reg    <= 2'h0;
            mdio_s_reg   <= 2'h3;
            mdc_d_reg    <= 1'b0;
        end else begin
            mdc_s_reg    <= {mdc_s_reg[0], mdc_i};
            mdio_s_reg   <= {mdio_s_reg[0], mdio_i};
            mdc_d_reg    <= mdc_s_reg[1];
        end
    end

    // Strap pins sample through reset, so release sees pins, not a reset value
    always_ff @(posedge clk_i) begin
        strap_s1_reg <= {mode_strap_pin_i, general_output_1_i, status_light_i};
        strap_s2_reg <= strap_s1_reg;
    end

    // Capture a few cycles after release, once the pin samples settled
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rel_reg        <= 1'b0;
            strap_done_reg <= 1'b0;
            addr_reg       <= pms_pkg::ADDR_DEFAULT;
            int_mode_reg   <= 1'b1;
        end else begin
            rel_reg <= 1'b1;
            if (rel_reg && !strap_done_reg) begin
                strap_done_reg <= 1'b1;
                addr_reg       <= strap_s2_reg[4:0];
                int_mode_reg   <= strap_s2_reg[5];
            end
        end
    end

    // Lights drive only after capture; polarity from each strap bit
    assign status_light_oe_n_o = !strap_done_reg;
    assign status_light_o = light_on_i ^ addr_reg[3:0];
    assign shared_pin_o   = int_mode_reg ? !irq_req_i : tx_err_i;
    assign int_mode_o     = int_mode_reg;
    assign phy_address_o  = addr_reg;

    // ------------------------------------------------------------
    // Serial management frame engine
    // ------------------------------------------------------------
    pms_state_t  state_reg, state_next;
    logic [5:0]  ones_reg;
    logic [3:0]  cnt_reg;
    logic [13:0] hdr_reg;
    logic [13:0] hdr_full;
    logic [15:0] sh_reg;
    logic        is_read_reg;
    logic        mdc_rise, mdc_fall, bit_in;
    logic        hdr_last, addr_ok, start_ok;
    logic        drive_reg;

    assign mdc_rise = mdc_s_reg[1] && !mdc_d_reg;
    assign mdc_fall = !mdc_s_reg[1] && mdc_d_reg;
    assign bit_in   = mdio_s_reg[1];
    // Header is complete with the bit taken at this rise
    assign hdr_full = {hdr_reg[12:0], bit_in};
    assign hdr_last = (state_reg == PMS_HEAD) && (cnt_reg == 4'd12);
    // hdr: start(2) op(2) phy(5) reg(5)
    assign start_ok = (hdr_full[13:12] == 2'b01);
    assign addr_ok  = rif.any_addr || (hdr_full[9:5] == addr_reg);

    // Next state only moves on clock edges; no timeout anywhere
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            PMS_IDLE: if (mdc_rise && !bit_in && ones_reg == 6'(pms_pkg::PREAMBLE_BITS)) begin
                state_next = PMS_HEAD;
            end
            PMS_HEAD: if (mdc_rise && hdr_last) begin
                state_next = (start_ok && addr_ok
                              && (hdr_full[11:10] == pms_pkg::OP_READ
                                  || hdr_full[11:10] == pms_pkg::OP_WRITE)) ? PMS_TA : PMS_SKIP;
            end
            PMS_TA:   if (mdc_rise && cnt_reg == 4'd1) begin
                state_next = PMS_DATA;
            end
            PMS_DATA: if (mdc_rise && cnt_reg == 4'd15) begin
                state_next = PMS_IDLE;
            end
            PMS_SKIP: if (mdc_rise && cnt_reg == 4'd15) begin
                state_next = PMS_IDLE;
            end
            default:  state_next = PMS_IDLE;
        endcase
    end

    // Frame sequencing
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= PMS_IDLE;
            ones_reg  <= 6'h00;
            cnt_reg   <= 4'h0;
            hdr_reg   <= 14'h0000;
            is_read_reg <= 1'b0;
        end else if (mdc_rise) begin
            state_reg <= state_next;
            ones_reg  <= (bit_in && state_reg == PMS_IDLE)
                         ? ((ones_reg == 6'(pms_pkg::PREAMBLE_BITS)) ? ones_reg : ones_reg + 6'd1)
                         : 6'h00;
            cnt_reg   <= (state_next != state_reg) ? 4'h0 : cnt_reg + 4'd1;
            if (state_reg == PMS_IDLE) begin
                hdr_reg <= {13'h0000, bit_in};
            end else if (state_reg == PMS_HEAD) begin
                hdr_reg <= {hdr_reg[12:0], bit_in};
            end
            if (hdr_last) begin
                is_read_reg <= hdr_full[11:10] == pms_pkg::OP_READ;
            end
        end
    end

    // Address of the frame, held from the header
    assign rif.addr   = hdr_reg[4:0];
    assign rif.wdata  = {sh_reg[14:0], bit_in};
    assign rif.wr_stb = mdc_rise && state_reg == PMS_DATA && cnt_reg == 4'd15 && !is_read_reg;

    // Read shifter loads at turnaround, shifts on falling edges
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sh_reg    <= 16'h0000;
            drive_reg <= 1'b0;
        end else if (state_reg == PMS_TA && is_read_reg && mdc_fall && cnt_reg == 4'd1) begin
            sh_reg    <= rif.rdata;
            drive_reg <= 1'b1;
        end else if (state_reg == PMS_TA && is_read_reg && mdc_fall) begin
            drive_reg <= 1'b0; // First turnaround bit left to the pull-up
            sh_reg    <= 16'h0000;
        end else if (state_reg == PMS_DATA && is_read_reg && mdc_fall && cnt_reg != 4'd0) begin
            sh_reg <= {sh_reg[14:0], 1'b0};
        end else if (state_reg == PMS_DATA && !is_read_reg && mdc_rise) begin
            sh_reg <= {sh_reg[14:0], bit_in};
        end else if (state_reg == PMS_IDLE) begin
            drive_reg <= 1'b0;
        end
    end

    // Open-drain: only pull low; turnaround second bit is zero
    assign mdio_o      = 1'b0;
    assign mdio_oe_n_o = !(drive_reg && (state_reg == PMS_TA || !sh_reg[15]));

    // ------------------------------------------------------------
    // Registers and derived mode
    // ------------------------------------------------------------
    pms_regfile #(
        .ID_HIGH (ID_HIGH),
        .ID_LOW  (ID_LOW)
    ) u_regs (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .link_up_i    (link_up_i),
        .an_done_i    (an_done_i),
        .rb           (rif),
        .control_o    (control_o),
        .an_restart_o (an_restart_o)
    );

    assign an_enable_o   = control_o[pms_pkg::CTL_AN_EN];
    // Forced mode only when negotiation is off
    assign speed_100_o   = an_enable_o ? 1'b1 : control_o[pms_pkg::CTL_SPEED];
    assign full_duplex_o = an_enable_o ? 1'b1 : control_o[pms_pkg::CTL_DUPLEX];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    strap_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        strap_done_reg |=> $stable(addr_reg) && $stable(int_mode_reg))
        else $error("strap changed after capture");
    strap_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rel_reg && !strap_done_reg |=> addr_reg == $past(strap_s2_reg[4:0]))
        else $error("address strap not taken");
    mode_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rel_reg && !strap_done_reg |=> int_mode_reg == $past(strap_s2_reg[5]))
        else $error("mode strap not taken");
    light_pol_a: assert property (@(posedge clk_i) disable iff (rst_i)
        status_light_o[0] == (light_on_i[0] ^ addr_reg[0]))
        else $error("light polarity wrong");
    unimpl_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (rif.addr > 5'h06 && rif.addr < 5'h10) |-> rif.rdata == 16'hFFFF)
        else $error("unimplemented register not all ones");
    step_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !mdc_rise |=> $stable(state_reg))
        else $error("frame advanced without clock rise");
    forced_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !control_o[12] |-> speed_100_o == control_o[13] && full_duplex_o == control_o[8])
        else $error("forced mode ignored");
    restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rif.wr_stb && rif.addr == 5'h00 && rif.wdata[9] |-> an_restart_o ##1 !control_o[9])
        else $error("restart not pulsed");
    no_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg == PMS_SKIP || state_reg == PMS_HEAD |-> mdio_oe_n_o)
        else $error("data driven outside read");
endmodule

// [pms_sm_model.sv]
`timescale 1ns/1ps
module pms_sm_model #(
    parameter int HALF_NS = 200
) (
    output logic      mdc_o,
    output logic      mdio_drv_n_o,
    input  wire logic mdio_i
);
    // ------------------------------------------------------------
    // Idle state
    // ------------------------------------------------------------
    initial begin
        mdc_o        = 1'b0;   // Clock stands low outside frames
        mdio_drv_n_o = 1'b1;
    end
    // ------------------------------------------------------------
    // Bit and frame tasks
    // ------------------------------------------------------------
    // One bit: data set after the fall, held across the rise
    task automatic clk_bit(input logic drive, input logic val, output logic smp);
        mdio_drv_n_o = drive ? val : 1'b1; // Only pulls low, pull-up wins
        #(HALF_NS);                        // 200 ns halves, 400 ns period
        mdc_o = 1'b1;
        smp   = mdio_i;                    // Taken at the rise
        #(HALF_NS);
        mdc_o = 1'b0;
    endtask
    // Whole frame; on a read the line is released from turnaround on
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [13:0] hdr;
        logic        s;
        logic        wr;
        hdr = {2'b01, op, phy, rg};
        wr  = (op == pms_pkg::OP_WRITE);
        for (int i = 0; i < pms_pkg::PREAMBLE_BITS; i++) begin
            clk_bit(1'b1, 1'b1, s);        // Preamble of ones
        end
        for (int i = 13; i >= 0; i--) begin
            clk_bit(1'b1, hdr[i], s);      // Start, op, addresses MSB first
        end
        clk_bit(wr, 1'b1, s);
        clk_bit(wr, 1'b0, s);
        for (int i = 15; i >= 0; i--) begin
            clk_bit(wr, wd[i], s);         // Data MSB first
            rd[i] = s;
        end
        mdio_drv_n_o = 1'b1;
    endtask
endmodule

// [pms_top_tb.sv]
`timescale 1ns/1ps
module pms_top_tb;
    localparam logic [15:0] ID_L = 16'h5A3C; // Arbitrary value
    logic        clk_i, rst_i, mdc, drv_n, mdio_line, mdio_o, mdio_oe_n_o, m;
    logic        general_output_1_i, mode_strap_pin_i, link_up_i, an_done_i;
    logic        irq_req_i, tx_err_i, status_light_oe_n_o, shared_pin_o, int_mode_o;
    logic        an_enable_o, speed_100_o, full_duplex_o, an_restart_o;
    logic [3:0]  status_light_i, light_on_i, status_light_o;
    logic [4:0]  phy_address_o, strap;
    logic [15:0] control_o, rd, w;
    int          err_count, samples_checked, cycles, restarts;
    // ------------------------------------------------------------
    // Wire level and instances
    // ------------------------------------------------------------
    // Open-drain line with pull-up: either party may pull low
    assign mdio_line = drv_n & (mdio_oe_n_o | mdio_o);
    pms_top #(.ID_LOW(ID_L)) u_pms_top (.clk_i(clk_i), .rst_i(rst_i), .mdc_i(mdc),
        .mdio_i(mdio_line), .mdio_o(mdio_o), .mdio_oe_n_o(mdio_oe_n_o),
        .status_light_i(status_light_i), .general_output_1_i(general_output_1_i),
        .mode_strap_pin_i(mode_strap_pin_i), .light_on_i(light_on_i), .link_up_i(link_up_i),
        .an_done_i(an_done_i), .irq_req_i(irq_req_i), .tx_err_i(tx_err_i),
        .status_light_o(status_light_o), .status_light_oe_n_o(status_light_oe_n_o),
        .shared_pin_o(shared_pin_o), .int_mode_o(int_mode_o), .phy_address_o(phy_address_o),
        .control_o(control_o), .an_enable_o(an_enable_o), .speed_100_o(speed_100_o),
        .full_duplex_o(full_duplex_o), .an_restart_o(an_restart_o));
    pms_sm_model u_pms_sm_model (.mdc_o(mdc), .mdio_drv_n_o(drv_n), .mdio_i(mdio_line));
    // ------------------------------------------------------------
    // Clock, watchdog, restart pulse counter
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (an_restart_o === 1'b1) restarts++;
        if (cycles == 90000) begin
            err_count++;
            tally_and_finish();
        end
    end
    // ------------------------------------------------------------
    // Tasks and expectations
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        if (err_count == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t reg got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [4:0] got, input logic [4:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t pin got %h exp %h", $time, got, exp);
        end
    endtask
    // Pins read low only where pulled down; reset spans 6 cycles
    task automatic apply_reset(input logic [4:0] s, input logic md);
        @(negedge clk_i);
        {general_output_1_i, status_light_i} = s; // Float or pull down
        mode_strap_pin_i = md;
        rst_i = 1'b1;
        repeat (6) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (10) @(negedge clk_i);
    endtask
    task automatic xfer(input logic [1:0] op, input logic [4:0] a, input logic [4:0] r,
                        input logic [15:0] d);
        @(negedge clk_i);
        u_pms_sm_model.frame(op, a, r, d, rd);
        repeat (8) @(negedge clk_i);
    endtask
    // Writable bits; reset and restart clear themselves
    function automatic logic [15:0] exp_ctl(input logic [15:0] v);
        return v & pms_pkg::CTL_WR_MASK & 16'h7DFF;
    endfunction
    function automatic logic [15:0] exp_sts();
        return pms_pkg::STATUS_CAPS | {10'h000, an_done_i, 2'b00, link_up_i, 2'b00};
    endfunction
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        {general_output_1_i, status_light_i, mode_strap_pin_i} = 6'h3F;
        {link_up_i, an_done_i, irq_req_i, tx_err_i, light_on_i} = 8'h00;
        void'($urandom(29618));
        strap = 5'($urandom);
        m     = 1'($urandom);
        {link_up_i, an_done_i, irq_req_i, tx_err_i, light_on_i} = 8'($urandom);
        apply_reset(strap, m);
        chk_pin(phy_address_o, strap);
        chk_pin({4'h0, int_mode_o}, {4'h0, m});
        chk_pin({4'h0, shared_pin_o}, {4'h0, m ? !irq_req_i : tx_err_i});
        chk_pin({1'b0, status_light_o}, {1'b0, light_on_i ^ strap[3:0]});
        chk_pin({4'h0, status_light_oe_n_o}, 5'h00);
        {general_output_1_i, status_light_i} = ~strap;
        mode_strap_pin_i = ~m;
        xfer(pms_pkg::OP_READ, strap, pms_pkg::REG_BASIC_CONTROL, 16'h0000);
        chk_reg(rd, pms_pkg::CTL_RESET_VAL);
        chk_pin(phy_address_o, strap);
        chk_pin({4'h0, int_mode_o}, {4'h0, m});
        chk_pin({2'b00, an_enable_o, speed_100_o, full_duplex_o}, 5'h07);
        xfer(pms_pkg::OP_READ, strap, pms_pkg::REG_BASIC_STATUS, 16'h0000);
        chk_reg(rd, exp_sts());
        xfer(pms_pkg::OP_READ, strap, pms_pkg::REG_IDENTIFIER_LOW, 16'h0000);
        chk_reg(rd, ID_L);
        xfer(pms_pkg::OP_READ, strap, 5'h07, 16'h0000);
        chk_reg(rd, pms_pkg::UNIMPL_VALUE);
        xfer(pms_pkg::OP_READ, strap, 5'h0F, 16'h0000);
        chk_reg(rd, pms_pkg::UNIMPL_VALUE);
        w = 16'($urandom) & 16'h6DFF;
        xfer(pms_pkg::OP_WRITE, strap, pms_pkg::REG_BASIC_CONTROL, w);
        chk_reg(control_o, exp_ctl(w));
        chk_pin({2'b00, an_enable_o, speed_100_o, full_duplex_o}, {3'b000, w[13], w[8]});
        restarts = 0;
        w[9] = 1'b1;
        xfer(pms_pkg::OP_WRITE, strap, pms_pkg::REG_BASIC_CONTROL, w);
        chk_pin(5'(restarts), 5'h01);
        chk_reg(control_o, exp_ctl(w));
        xfer(pms_pkg::OP_WRITE, strap ^ 5'h01, pms_pkg::REG_BASIC_CONTROL, 16'h1000);
        chk_reg(control_o, exp_ctl(w));
        xfer(pms_pkg::OP_WRITE, strap, pms_pkg::REG_MODE_CTRL, 16'h0008);
        xfer(pms_pkg::OP_READ, strap ^ 5'h01, pms_pkg::REG_BASIC_CONTROL, 16'h0000);
        chk_reg(rd, exp_ctl(w));
        xfer(pms_pkg::OP_READ, strap ^ 5'h10, pms_pkg::REG_MODE_CTRL, 16'h0000);
        chk_reg(rd, 16'h0008);
        apply_reset(~strap, ~m);
        chk_pin(phy_address_o, ~strap);
        chk_reg(control_o, pms_pkg::CTL_RESET_VAL);
        tally_and_finish();
    end
endmodule
